// *** src/wsbs_defines.vh ***
`ifndef WSBS_DEFINES_VH
`define WSBS_DEFINES_VH
// command codes
`define WSBS_CMD_BATCH_OPEN 8'hbd
`define WSBS_CMD_BATCH_CLOSE 8'hbe
`define WSBS_CMD_STATUS 8'hcc
// reply codes
`define WSBS_WHEEL3_PREFIX 8'hfc
`define WSBS_SHUT1_OPEN 8'haa
`define WSBS_SHUT1_COND 8'hab
`define WSBS_SHUT1_CLOSED 8'hac
`define WSBS_SHUT2_OPEN 8'hba
`define WSBS_SHUT2_COND 8'hbb
`define WSBS_SHUT2_CLOSED 8'hbc
`define WSBS_MODE_NONE 8'hdb
`define WSBS_MODE_FAST 8'hdc
`define WSBS_MODE_SOFT 8'hdd
`define WSBS_MODE_ND 8'hde
// shutter state codes at the unit side
`define WSBS_SST_OPEN 2'h0
`define WSBS_SST_COND 2'h1
`define WSBS_SST_CLOSED 2'h2
// shutter mode codes at the unit side
`define WSBS_SMD_NONE 2'h0
`define WSBS_SMD_FAST 2'h1
`define WSBS_SMD_SOFT 2'h2
`define WSBS_SMD_ND 2'h3
// wheel byte fields
`define WSBS_WHEEL_BIT 7
`define WSBS_SPEED_MSB 6
`define WSBS_SPEED_LSB 4
`define WSBS_POS_MSB 3
`define WSBS_POS_LSB 0
`define WSBS_POS_MAX 4'h9
// batch and ND step count limits
`define WSBS_BATCH_MAX 3'h6
`define WSBS_ND_STEP_MIN 8'h01
`define WSBS_ND_STEP_MAX 8'h90
`endif

// *** src/wsbs_reply.v ***
`timescale 1ns/1ps
`default_nettype none
`include "wsbs_defines.vh"
module wsbs_reply (
    // clock and reset
    input wire i_mclk,
    input wire i_sys_rst,
    // request
    input wire i_start,
    input wire [4:0] i_installed,
    input wire [6:0] i_wheel1,
    input wire [6:0] i_wheel2,
    input wire [6:0] i_wheel3,
    input wire [1:0] i_shut1_state,
    input wire [1:0] i_shut2_state,
    input wire [1:0] i_shut1_mode,
    input wire [7:0] i_shut1_steps,
    // reply byte stream
    output reg [7:0] o_tx_data,
    output reg o_tx_valid,
    input wire i_tx_ready,
    output wire o_busy
);
    reg [3:0] step;
    reg [3:0] next_step;
    reg [7:0] next_byte;
    reg next_valid;

    function [7:0] wheel_byte;
        input msb;
        input [6:0] w;
        begin
            // speed and position fields
            wheel_byte = {msb, w[6:4], (w[3:0] > `WSBS_POS_MAX) ? 4'h0 : w[3:0]};
        end
    endfunction

    assign o_busy = (step != 4'h0) || o_tx_valid;

    // pick next byte, skipping absent units
    always @* begin
        next_step = step;
        next_byte = 8'h00;
        next_valid = 1'b0;
        case (step)
            4'h1: begin
                // [RQ6] status echo
                next_byte = `WSBS_CMD_STATUS;
                next_valid = 1'b1;
                next_step = 4'h2;
            end
            4'h2: begin
                // [RQ7] [RQ8] [RQ9] first wheel
                next_byte = wheel_byte(1'b0, i_wheel1);
                next_valid = i_installed[0];
                next_step = 4'h3;
            end
            4'h3: begin
                // [RQ10] second wheel
                next_byte = wheel_byte(1'b1, i_wheel2);
                next_valid = i_installed[1];
                next_step = 4'h4;
            end
            4'h4: begin
                // [RQ11] third wheel prefix
                next_byte = `WSBS_WHEEL3_PREFIX;
                next_valid = i_installed[2];
                next_step = 4'h5;
            end
            4'h5: begin
                next_byte = wheel_byte(1'b0, i_wheel3);
                next_valid = i_installed[2];
                next_step = 4'h6;
            end
            4'h6: begin
                // [RQ12] [RQ14] first shutter
                case (i_shut1_state)
                    `WSBS_SST_OPEN: next_byte = `WSBS_SHUT1_OPEN;
                    `WSBS_SST_COND: next_byte = `WSBS_SHUT1_COND;
                    default: next_byte = `WSBS_SHUT1_CLOSED;
                endcase
                next_valid = i_installed[3];
                next_step = 4'h7;
            end
            4'h7: begin
                // [RQ13] second shutter
                case (i_shut2_state)
                    `WSBS_SST_OPEN: next_byte = `WSBS_SHUT2_OPEN;
                    `WSBS_SST_COND: next_byte = `WSBS_SHUT2_COND;
                    default: next_byte = `WSBS_SHUT2_CLOSED;
                endcase
                next_valid = i_installed[4];
                next_step = 4'h8;
            end
            4'h8: begin
                // [RQ15] [RQ16] mode code
                case (i_shut1_mode)
                    `WSBS_SMD_FAST: next_byte = `WSBS_MODE_FAST;
                    `WSBS_SMD_SOFT: next_byte = `WSBS_MODE_SOFT;
                    `WSBS_SMD_ND: next_byte = `WSBS_MODE_ND;
                    default: next_byte = `WSBS_MODE_NONE;
                endcase
                next_valid = 1'b1;
                next_step = 4'h9;
            end
            4'h9: begin
                // port number
                next_byte = 8'h01;
                next_valid = 1'b1;
                next_step = (i_shut1_mode == `WSBS_SMD_ND) ? 4'ha : 4'h0;
            end
            4'ha: begin
                // [RQ16] microstep count
                if (i_shut1_steps < `WSBS_ND_STEP_MIN) begin
                    next_byte = `WSBS_ND_STEP_MIN;
                end else if (i_shut1_steps > `WSBS_ND_STEP_MAX) begin
                    next_byte = `WSBS_ND_STEP_MAX;
                end else begin
                    next_byte = i_shut1_steps;
                end
                next_valid = 1'b1;
                next_step = 4'h0;
            end
            default: begin
                next_step = 4'h0;
            end
        endcase
    end

    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            step <= 4'h0;
            o_tx_data <= 8'h00;
            o_tx_valid <= 1'b0;
        end else if (o_tx_valid) begin
            if (i_tx_ready) begin
                o_tx_valid <= 1'b0;
            end
        end else if (step == 4'h0) begin
            if (i_start) begin
                step <= 4'h1;
            end
        end else begin
            step <= next_step;
            o_tx_data <= next_byte;
            o_tx_valid <= next_valid;
        end
    end
endmodule // wsbs_reply
`default_nettype wire

// *** src/wsbs_top.v ***
// Summary of operation
// [RQ1] The host sends one to six wheel or shutter bytes between batch open and close.
// [RQ2] Each batch item is one byte, except the third wheel which is a prefix then a byte.
// [RQ3] Any subset of the three wheels and two shutters is accepted in a batch.
// [RQ4] Batch items are held and only issued, back to back, after the close byte.
// [RQ5] The status reply carries wheel and shutter bytes only for installed units.
// [RQ6] The first status reply byte echoes the status code 0xcc.
// [RQ7] The second reply byte is the first wheel with bit 7 clear, value 0 to 121.
// [RQ8] Bits 6 to 4 of each wheel status byte hold the speed 0 to 7.
// [RQ9] Bits 3 to 0 of each wheel status byte hold the position 0 to 9.
// [RQ10] The third reply byte is the second wheel with bit 7 set, value 128 to 249.
// [RQ11] The third wheel reports as 0xfc then a wheel byte with bit 7 clear.
// [RQ12] The first shutter reports 170 open, 171 conditional, 172 closed.
// [RQ13] The second shutter reports 186 open, 187 conditional, 188 closed.
// [RQ14] Conditional open means the shutter follows its own wheel's motion.
// [RQ15] The mode report is two or three bytes, 219 then port 1 when absent.
// [RQ16] Mode codes 220 fast, 221 soft, 222 neutral density plus a 1 to 144 step count.
// [RQ17] Batch open is 0xbd and batch close is 0xbe.
`timescale 1ns/1ps
`default_nettype none
`include "wsbs_defines.vh"
module wsbs_top (
    // clock and reset
    input wire i_mclk,
    input wire i_sys_rst,
    // received command bytes
    input wire [7:0] i_rx_data,
    input wire i_rx_valid,
    // reply bytes
    output wire [7:0] o_tx_data,
    output wire o_tx_valid,
    input wire i_tx_ready,
    // unit state
    input wire [4:0] i_installed,
    input wire [6:0] i_wheel1,
    input wire [6:0] i_wheel2,
    input wire [6:0] i_wheel3,
    input wire [1:0] i_shut1_state,
    input wire [1:0] i_shut2_state,
    input wire [1:0] i_shut1_mode,
    input wire [7:0] i_shut1_steps,
    // batch execution stream
    output reg [7:0] o_exec_data,
    output reg o_exec_third,
    output reg o_exec_valid,
    output reg o_batch_error,
    output wire o_batch_busy
);
    ////////////////////////////////////////////////////////////////
    reg [7:0] item_mem [0:5];
    reg [5:0] item_third;
    reg [2:0] count;
    reg [2:0] rd_ptr;
    reg collecting;
    reg executing;
    reg prefix_seen;
    reg status_go;
    wire reply_busy;

    // busy until the last executed item has left the port
    assign o_batch_busy = collecting || executing || o_exec_valid;

    ////////////////////////////////////////////////////////////////
    // batch collect and execute
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            count <= 3'h0;
            rd_ptr <= 3'h0;
            item_third <= 6'h00;
            collecting <= 1'b0;
            executing <= 1'b0;
            prefix_seen <= 1'b0;
            status_go <= 1'b0;
            o_exec_data <= 8'h00;
            o_exec_third <= 1'b0;
            o_exec_valid <= 1'b0;
            o_batch_error <= 1'b0;
        end else begin
            o_exec_valid <= 1'b0;
            status_go <= 1'b0;
            if (executing) begin
                // [RQ4] issue held items back to back
                o_exec_data <= item_mem[rd_ptr];
                o_exec_third <= item_third[rd_ptr];
                o_exec_valid <= 1'b1;
                rd_ptr <= rd_ptr + 3'h1;
                if (rd_ptr + 3'h1 == count) begin
                    executing <= 1'b0;
                end
            end else if (i_rx_valid) begin
                if (!collecting) begin
                    // [RQ17] batch open code
                    if (i_rx_data == `WSBS_CMD_BATCH_OPEN) begin
                        collecting <= 1'b1;
                        count <= 3'h0;
                        item_third <= 6'h00;
                        prefix_seen <= 1'b0;
                        o_batch_error <= 1'b0;
                    end else if (i_rx_data == `WSBS_CMD_STATUS && !reply_busy) begin
                        status_go <= 1'b1;
                    end
                end else if (i_rx_data == `WSBS_CMD_BATCH_CLOSE) begin
                    // [RQ1] [RQ4] close starts execution
                    collecting <= 1'b0;
                    rd_ptr <= 3'h0;
                    executing <= (count != 3'h0) && !prefix_seen;
                    o_batch_error <= (count == 3'h0) || prefix_seen;
                end else if (i_rx_data == `WSBS_WHEEL3_PREFIX && !prefix_seen) begin
                    // [RQ2] third wheel prefix
                    prefix_seen <= 1'b1;
                end else if (count == `WSBS_BATCH_MAX) begin
                    collecting <= 1'b0;
                    o_batch_error <= 1'b1;
                end else begin
                    // [RQ2] [RQ3] store any unit item
                    item_mem[count] <= i_rx_data;
                    item_third[count] <= prefix_seen;
                    prefix_seen <= 1'b0;
                    count <= count + 3'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // [RQ5] status reply generator
    wsbs_reply u_reply (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_start(status_go),
        .i_installed(i_installed),
        .i_wheel1(i_wheel1),
        .i_wheel2(i_wheel2),
        .i_wheel3(i_wheel3),
        .i_shut1_state(i_shut1_state),
        .i_shut2_state(i_shut2_state),
        .i_shut1_mode(i_shut1_mode),
        .i_shut1_steps(i_shut1_steps),
        .o_tx_data(o_tx_data),
        .o_tx_valid(o_tx_valid),
        .i_tx_ready(i_tx_ready),
        .o_busy(reply_busy)
    );
endmodule // wsbs_top
`default_nettype wire

// *** tb/wsbs_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module wsbs_properties (
    // watched ports
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_valid,
    input wire logic [7:0] o_tx_data,
    input wire logic o_tx_valid,
    input wire logic i_tx_ready,
    input wire logic [4:0] i_installed,
    input wire logic [6:0] i_wheel1,
    input wire logic o_exec_valid,
    input wire logic [7:0] o_exec_data,
    input wire logic o_batch_busy
);
    logic [7:0] last;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    // last reply byte taken by the host
    always @(posedge i_mclk)
        if (i_sys_rst) last <= 8'h00;
        else if (o_tx_valid && i_tx_ready) last <= o_tx_data;
    sequence s_new_byte;
        $rose(o_tx_valid);
    endsequence
    sequence s_held;
        o_tx_valid && !i_tx_ready;
    endsequence
    chk_tx_hold:
    assert property (s_held |=> o_tx_valid && $stable(o_tx_data)) else $error("reply byte moved");
    chk_echo_cause:
    assert property ((s_new_byte and (o_tx_data == 8'hcc)) |-> $past(i_rx_valid, 3)
        && $past(i_rx_data, 3) == 8'hcc) else $error("echo without request");
    chk_wheel1_byte:
    assert property ((s_new_byte and (last == 8'hcc && i_installed[0])) |-> o_tx_data ==
        {1'b0, i_wheel1[6:4], (i_wheel1[3:0] > 4'h9) ? 4'h0 : i_wheel1[3:0]})
        else $error("first wheel byte wrong");
    chk_wheel3_byte:
    assert property ((s_new_byte and (last == 8'hfc)) |-> !o_tx_data[7]
        && o_tx_data[3:0] <= 4'h9)
        else $error("third wheel byte wrong");
    chk_mode_port:
    assert property ((s_new_byte and (last inside {[8'hdb:8'hde]})) |-> o_tx_data == 8'h01)
        else $error("mode port byte wrong");
    chk_exec_after_close:
    assert property ($rose(o_exec_valid) |-> $past(i_rx_valid, 2)
        && $past(i_rx_data, 2) == 8'hbe)
        else $error("execution without close");
    chk_exec_idle:
    assert property (!o_batch_busy |-> !o_exec_valid && $stable(o_exec_data))
        else $error("execution while idle");
    chk_exec_six:
    assert property (o_exec_valid [*6] |=> !o_exec_valid) else $error("over six items");
endmodule // wsbs_properties
`default_nettype wire

// *** tb/wsbs_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module wsbs_host (
    // control
    input wire logic i_mclk,
    input wire logic i_slow,
    // link
    output logic [7:0] o_rx_data,
    output logic o_rx_valid,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_valid,
    output logic o_tx_ready
);
    logic [7:0] got[$];
    logic [1:0] ph;
    initial begin
        o_rx_data = 8'h00;
        o_rx_valid = 1'b0;
        o_tx_ready = 1'b0;
        ph = 2'h0;
    end
    task send(input logic [7:0] b);
        @(posedge i_mclk);
        o_rx_data <= b;
        o_rx_valid <= 1'b1;
        @(posedge i_mclk);
        o_rx_valid <= 1'b0;
        o_rx_data <= ~b;
    endtask
    // reply sink, stalls when slow
    always @(posedge i_mclk) begin
        ph <= ph + 2'h1;
        o_tx_ready <= !i_slow || ph == 2'h3;
        if (i_tx_valid && o_tx_ready) got.push_back(i_tx_data);
    end
endmodule // wsbs_host
`default_nettype wire

// *** tb/wsbs_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module wsbs_top_tb;
    logic i_mclk, i_sys_rst, i_rx_valid, o_tx_valid, i_tx_ready, slow;
    logic o_exec_third, o_exec_valid, o_batch_error, o_batch_busy;
    logic [7:0] i_rx_data, o_tx_data, o_exec_data, i_shut1_steps;
    logic [4:0] i_installed;
    logic [6:0] i_wheel1, i_wheel2, i_wheel3;
    logic [1:0] i_shut1_state, i_shut2_state, i_shut1_mode;
    logic [8:0] ex[$];
    int bad_count, samples_checked, cyc;
    wsbs_top u_dut (.i_mclk, .i_sys_rst, .i_rx_data, .i_rx_valid, .o_tx_data, .o_tx_valid,
        .i_tx_ready, .i_installed, .i_wheel1, .i_wheel2, .i_wheel3, .i_shut1_state,
        .i_shut2_state, .i_shut1_mode, .i_shut1_steps, .o_exec_data, .o_exec_third,
        .o_exec_valid, .o_batch_error, .o_batch_busy);
    wsbs_host u_host (.i_mclk, .i_slow(slow), .o_rx_data(i_rx_data), .o_rx_valid(i_rx_valid),
        .i_tx_data(o_tx_data), .i_tx_valid(o_tx_valid), .o_tx_ready(i_tx_ready));
    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (o_exec_valid) ex.push_back({o_exec_third, o_exec_data});
        if (cyc == 6000) begin
            bad_count++;
            close_out;
        end
    end
    task chk(input logic [8:0] got, input logic [8:0] want);
        samples_checked++;
        if (got !== want) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, got, want);
        end
    endtask
    task wait_idle;
        for (int i = 0; i < 60; i++) begin
            @(posedge i_mclk);
            #1;
            if (!o_batch_busy) break;
        end
    endtask
    function automatic logic [7:0] wb(input logic msb, input logic [6:0] w);
        return {msb, w[6:4], (w[3:0] > 4'h9) ? 4'h0 : w[3:0]};
    endfunction
    task close_out;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    task t_batch_mixed;
        logic [8:0] e[$];
        e = {9'h012, 9'h135, 9'h0aa, 9'h097};
        ex.delete();
        u_host.send(8'hbd);
        foreach (e[i]) begin
            if (e[i][8]) u_host.send(8'hfc);
            u_host.send(e[i][7:0]);
        end
        repeat (4) @(posedge i_mclk);
        chk(9'(ex.size()), 9'h0);
        u_host.send(8'hbe);
        wait_idle;
        chk(9'(ex.size()), 9'(e.size()));
        foreach (e[i]) chk(ex[i], e[i]);
        chk({8'h00, o_batch_error}, 9'h0);
    endtask
    task t_batch_limit(input int n);
        ex.delete();
        u_host.send(8'hbd);
        repeat (n) u_host.send(8'h21);
        u_host.send(8'hbe);
        wait_idle;
        chk(9'(ex.size()), (n > 6 || n == 0) ? 9'h0 : 9'(n));
        chk({8'h00, o_batch_error}, {8'h00, n > 6 || n == 0});
    endtask
    task t_status(input logic [4:0] in, input logic [6:0] a, b, c, input logic [1:0] p, q, m,
        input logic [7:0] st, input logic sl);
        logic [7:0] e[$];
        @(posedge i_mclk);
        i_installed <= in;
        i_wheel1 <= a;
        i_wheel2 <= b;
        i_wheel3 <= c;
        i_shut1_state <= p;
        i_shut2_state <= q;
        i_shut1_mode <= m;
        i_shut1_steps <= st;
        slow <= sl;
        e = {8'hcc};
        if (in[0]) e.push_back(wb(1'b0, a));
        if (in[1]) e.push_back(wb(1'b1, b));
        if (in[2]) e.push_back(8'hfc);
        if (in[2]) e.push_back(wb(1'b0, c));
        if (in[3]) e.push_back(8'haa + p);
        if (in[4]) e.push_back(8'hba + q);
        e.push_back(8'hdb + m);
        e.push_back(8'h01);
        if (m == 2'h3) e.push_back((st == 8'h00) ? 8'h01 : (st > 8'h90) ? 8'h90 : st);
        u_host.got.delete();
        u_host.send(8'hcc);
        for (int i = 0; i < 300 && u_host.got.size() < e.size(); i++) @(posedge i_mclk);
        repeat (8) @(posedge i_mclk);
        chk(9'(u_host.got.size()), 9'(e.size()));
        foreach (e[i]) chk({1'b0, u_host.got[i]}, {1'b0, e[i]});
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        {i_sys_rst, slow, cyc, bad_count, samples_checked} = {2'b10, 96'h0};
        {i_installed, i_wheel1, i_shut1_state, i_shut2_state, i_shut1_mode} = '0;
        {i_wheel2, i_wheel3, i_shut1_steps} = '0;
        repeat (12) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        t_batch_mixed;
        t_batch_limit(6);
        t_batch_limit(7);
        t_batch_limit(0);
        t_status(5'h1f, 7'h79, 7'h05, 7'h73, 2'h0, 2'h1, 2'h3, 8'h90, 1'b0);
        t_status(5'h1f, 7'h3c, 7'h5c, 7'h2a, 2'h1, 2'h2, 2'h1, 8'h00, 1'b0);
        t_status(5'h1f, 7'h00, 7'h79, 7'h4b, 2'h2, 2'h0, 2'h2, 8'h00, 1'b1);
        t_status(5'h12, 7'h11, 7'h36, 7'h00, 2'h0, 2'h2, 2'h0, 8'h00, 1'b0);
        t_status(5'h04, 7'h00, 7'h00, 7'h7f, 2'h0, 2'h0, 2'h3, 8'h00, 1'b1);
        close_out;
    end
endmodule // wsbs_top_tb
bind wsbs_top wsbs_properties u_props (.i_mclk, .i_sys_rst, .i_rx_data, .i_rx_valid,
    .o_tx_data, .o_tx_valid, .i_tx_ready, .i_installed, .i_wheel1, .o_exec_valid, .o_exec_data,
    .o_batch_busy);
`default_nettype wire
